// ===== psv_pkg.sv
// Purpose: shared constants and types of the phase sync and vector irq block
// Assumes: apb word addressing, printed offsets are register indexes
// Notes:   byte address of a register is four times its index
package psv_pkg;

  typedef logic [9:0] psv_addr_t;

  // register indexes
  localparam logic [7:0] PSV_IDX_MATCH_A   = 8'h12;
  localparam logic [7:0] PSV_IDX_MATCH_B   = 8'h14;
  localparam logic [7:0] PSV_IDX_USAGE     = 8'h16;
  localparam logic [7:0] PSV_IDX_EXT_CFG   = 8'h18;
  localparam logic [7:0] PSV_IDX_PENDING   = 8'h70;
  localparam logic [7:0] PSV_IDX_SRC_EN    = 8'h74;
  localparam logic [7:0] PSV_IDX_VEC_EN    = 8'h78;
  localparam logic [7:0] PSV_IDX_VEC_DIS   = 8'h7A;
  localparam logic [7:0] PSV_IDX_CEILING   = 8'h7C;
  localparam logic [7:0] PSV_IDX_CUR_VEC   = 8'h7E;

  // reset values
  localparam logic [15:0] PSV_RST_ZERO     = 16'h0000;
  localparam logic [3:0]  PSV_RST_CEILING  = 4'h9;

  // usage field codes
  localparam logic [1:0] PSV_USE_OFF       = 2'h0;
  localparam logic [1:0] PSV_USE_A_RELOAD  = 2'h1;
  localparam logic [1:0] PSV_USE_A_MATCH   = 2'h2;
  localparam logic [1:0] PSV_USE_B_CAPTURE = 2'h1;
  localparam logic [1:0] PSV_USE_B_MATCH   = 2'h2;

  // field positions
  localparam int PSV_USE_A_LSB   = 0;
  localparam int PSV_USE_B_LSB   = 2;
  localparam int PSV_EXT_SRC_LSB = 0;
  localparam int PSV_EXT_THR_LSB = 2;
  localparam int PSV_EXT_PRE_LSB = 10;
  localparam int PSV_EXT_EDGE    = 12;
  localparam int PSV_VAL_W       = 12;

  // filter preset commands
  localparam logic [1:0] PSV_PRESET_ZERO = 2'h2;
  localparam logic [1:0] PSV_PRESET_ONE  = 2'h3;

  // interrupt sources
  localparam int         PSV_NUM_SRC     = 9;
  localparam logic [3:0] PSV_VEC_NONE    = 4'h9;

  function automatic psv_addr_t psv_byte_addr(input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction

endpackage

// ===== psv_sync_if.sv
// Purpose: carries filter control and capture events between top and filter
// Assumes: single clock domain
// Notes:   preset_go is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface psv_sync_if;
  logic [1:0] src;
  logic [7:0] thr;
  logic       edge_fall;
  logic       preset_go;
  logic       preset_val;
  logic       capture;
  logic       filt_state;

  modport ctl (output src, thr, edge_fall, preset_go, preset_val,
               input  capture, filt_state);
  modport flt (input  src, thr, edge_fall, preset_go, preset_val,
               output capture, filt_state);
endinterface
`default_nettype wire

// ===== psv_sync_filter.sv
// Purpose: external sync select, integration filter and capture edge detect
// Assumes: ext sync inputs synchronous to clk_i
// Notes:   capture is a one-cycle pulse, set on the same edge as the filtered change
`timescale 1ns/1ps
`default_nettype none
module psv_sync_filter (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // sync inputs
  input  wire logic [3:0] ext_sync_i,
  // control
  psv_sync_if.flt         sif
);
  import psv_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
    logic       state;
    logic       capture;
  } psv_filt_state_t;

  psv_filt_state_t s_r;
  psv_filt_state_t s_nxt;
  logic            raw;

  always_comb begin
    s_nxt         = s_r;
    s_nxt.capture = 1'b0;
    raw           = ext_sync_i[sif.src];
    if (sif.preset_go) begin
      // preset forces the state without a capture event
      s_nxt.state = sif.preset_val;
      s_nxt.cnt   = 8'h00;
    end else if (raw != s_r.state) begin
      if (({1'b0, s_r.cnt} + 9'h001) >= {1'b0, sif.thr}) begin
        s_nxt.state   = raw;
        s_nxt.cnt     = 8'h00;
        s_nxt.capture = (raw == ~sif.edge_fall);
      end else begin
        s_nxt.cnt = s_r.cnt + 8'h01;
      end
    end else begin
      s_nxt.cnt = 8'h00;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign sif.capture    = s_r.capture;
  assign sif.filt_state = s_r.state;

  a_filter_preset_state: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && sif.preset_go) |=> (s_r.state == $past(sif.preset_val) && !s_r.capture))
    else $error("filter preset did not force state");

  a_capture_edge_dir: assert property (@(posedge clk_i) disable iff (rst_i)
    s_r.capture |-> (s_r.state == ~$past(sif.edge_fall) && $past(s_r.state) != s_r.state))
    else $error("capture on wrong edge");

  a_filter_below_thr: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !sif.preset_go && ({1'b0, s_r.cnt} + 9'h001) < {1'b0, sif.thr})
    |=> $stable(s_r.state))
    else $error("filter changed before threshold");

  a_filter_follow_src: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !sif.preset_go && ext_sync_i[sif.src] == s_r.state)
    |=> ($stable(s_r.state) && !s_r.capture))
    else $error("filter moved without selected input");

endmodule // psv_sync_filter
`default_nettype wire

// ===== psv_top.sv
// Purpose: phase compare sync logic and vector interrupt block with apb slave
// Assumes: apb3 without pstrb, zero wait access phase, 32-bit data
// Notes:   registers are 16 bits wide in the low half of each word
// What this block does
// - first usage field: 00 unused, 01 match plus sync reload, 10 match only.
// - second usage field: 00 unused, 01 sync capture, 10 phase match.
// - each phase compare register holds 12 writable bits, upper bits read zero.
// - capture on filtered rising edge when edge bit is 0, falling when 1.
// - preset 10 clears filter to state 0, preset 11 clears it to state 1.
// - 8-bit threshold must be reached before filtered sync state changes.
// - two-bit source field selects one of four external sync inputs.
// - nine pending sources: matches, three reloads, reload error, three dma idles.
// - pending bit 1 set by second match or by sync capture.
// - nine-bit enable mask gates sources, all disabled after reset.
// - writing a vector to the enable port enables only that source.
// - writing a vector to the disable port disables only that source.
// - software writes current vector to ceiling; only lower vectors interrupt; resets 9.
// - current vector reads lowest numbered enabled pending source.
// - with nothing enabled pending, current vector reads the first unused number.
// - writing a vector to current vector clears only that pending flag.
// - first match fires on increment when accumulator equals first compare value.
// - with second usage field 01, each sync capture copies the phase accumulator into the second register.
`timescale 1ns/1ps
`default_nettype none
module psv_top (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire psv_pkg::psv_addr_t paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // phase accumulator
  input  wire logic [11:0] phase_acc_i,
  input  wire logic        phase_inc_i,
  // external sync inputs
  input  wire logic [3:0]  ext_sync_i,
  // channel events
  input  wire logic [2:0]  reload_evt_i,
  input  wire logic        reload_err_i,
  input  wire logic [2:0]  dma_idle_i,
  // outputs
  output logic             irq_o,
  output logic             sync_reload_o
);
  import psv_pkg::*;

  typedef struct packed {
    logic [11:0] match_a;
    logic [11:0] match_b;
    logic [1:0]  use_a;
    logic [1:0]  use_b;
    logic        edge_fall;
    logic [1:0]  preset_fld;
    logic [7:0]  thr;
    logic [1:0]  src;
    logic [8:0]  pend;
    logic [8:0]  mask;
    logic [3:0]  ven;
    logic [3:0]  vdis;
    logic [3:0]  ceil;
    logic [15:0] rdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        sync_reload;
    logic        preset_go;
    logic        preset_val;
  } psv_top_state_t;

  // lowest set bit wins, none set gives the first unused vector
  function automatic logic [3:0] psv_first(input logic [8:0] v);
    logic [3:0] r;
    r = PSV_VEC_NONE;
    for (int i = PSV_NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // out-of-range vectors select nothing
  function automatic logic [8:0] psv_onehot(input logic [3:0] v);
    logic [8:0] r;
    r = 9'h000;
    for (int i = 0; i < PSV_NUM_SRC; i++) begin
      if (v == 4'(i)) begin
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction

  psv_top_state_t s_r;
  psv_top_state_t s_nxt;
  psv_sync_if     sif ();

  logic       setup;
  logic       wr;
  logic       match_a_evt;
  logic       match_b_evt;
  logic       capture_evt;
  logic [8:0] set_vec;
  logic [8:0] clr_vec;
  logic [3:0] cur_vec;
  logic       hit;
  logic [15:0] rd_val;

  psv_sync_filter u_filter (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .ext_sync_i (ext_sync_i),
    .sif        (sif)
  );

  assign sif.src        = s_r.src;
  assign sif.thr        = s_r.thr;
  assign sif.edge_fall  = s_r.edge_fall;
  assign sif.preset_go  = s_r.preset_go;
  assign sif.preset_val = s_r.preset_val;

  always_comb begin
    s_nxt = s_r;
    setup = psel_i && !penable_i;
    // write lands on the completing edge only
    wr    = psel_i && penable_i && s_r.pready && pwrite_i;

    // events
    match_a_evt = phase_inc_i && (s_r.use_a != PSV_USE_OFF)
                  && (phase_acc_i == s_r.match_a);
    match_b_evt = phase_inc_i && (s_r.use_b == PSV_USE_B_MATCH)
                  && (phase_acc_i == s_r.match_b);
    capture_evt = sif.capture && (s_r.use_b == PSV_USE_B_CAPTURE);
    s_nxt.sync_reload = match_a_evt && (s_r.use_a == PSV_USE_A_RELOAD);

    set_vec = {dma_idle_i, reload_err_i, reload_evt_i,
               match_b_evt || capture_evt, match_a_evt};
    cur_vec = psv_first(s_r.pend & s_r.mask);

    // register decode and read mux
    hit    = 1'b1;
    rd_val = PSV_RST_ZERO;
    unique case (paddr_i)
      psv_byte_addr(PSV_IDX_MATCH_A): rd_val = {4'h0, s_r.match_a};
      psv_byte_addr(PSV_IDX_MATCH_B): rd_val = {4'h0, s_r.match_b};
      psv_byte_addr(PSV_IDX_USAGE):   rd_val = {12'h000, s_r.use_b, s_r.use_a};
      psv_byte_addr(PSV_IDX_EXT_CFG): rd_val = {3'h0, s_r.edge_fall, s_r.preset_fld,
                                                s_r.thr, s_r.src};
      psv_byte_addr(PSV_IDX_PENDING): rd_val = {7'h00, s_r.pend};
      psv_byte_addr(PSV_IDX_SRC_EN):  rd_val = {7'h00, s_r.mask};
      psv_byte_addr(PSV_IDX_VEC_EN):  rd_val = {12'h000, s_r.ven};
      psv_byte_addr(PSV_IDX_VEC_DIS): rd_val = {12'h000, s_r.vdis};
      psv_byte_addr(PSV_IDX_CEILING): rd_val = {12'h000, s_r.ceil};
      psv_byte_addr(PSV_IDX_CUR_VEC): rd_val = {12'h000, cur_vec};
      default:                        hit    = 1'b0;
    endcase

    // answer one cycle after setup, i.e. in the first access cycle
    s_nxt.pready  = setup;
    s_nxt.pslverr = setup && !hit;
    if (setup) begin
      s_nxt.rdata = pwrite_i ? PSV_RST_ZERO : rd_val;
    end

    clr_vec         = 9'h000;
    s_nxt.preset_go = 1'b0;
    if (wr && !s_r.pslverr) begin
      unique case (paddr_i)
        psv_byte_addr(PSV_IDX_MATCH_A): s_nxt.match_a = pwdata_i[PSV_VAL_W-1:0];
        psv_byte_addr(PSV_IDX_MATCH_B): s_nxt.match_b = pwdata_i[PSV_VAL_W-1:0];
        psv_byte_addr(PSV_IDX_USAGE): begin
          s_nxt.use_a = pwdata_i[PSV_USE_A_LSB +: 2];
          s_nxt.use_b = pwdata_i[PSV_USE_B_LSB +: 2];
        end
        psv_byte_addr(PSV_IDX_EXT_CFG): begin
          s_nxt.src        = pwdata_i[PSV_EXT_SRC_LSB +: 2];
          s_nxt.thr        = pwdata_i[PSV_EXT_THR_LSB +: 8];
          s_nxt.preset_fld = pwdata_i[PSV_EXT_PRE_LSB +: 2];
          s_nxt.edge_fall  = pwdata_i[PSV_EXT_EDGE];
          s_nxt.preset_go  = (pwdata_i[PSV_EXT_PRE_LSB +: 2] == PSV_PRESET_ZERO)
                             || (pwdata_i[PSV_EXT_PRE_LSB +: 2] == PSV_PRESET_ONE);
          s_nxt.preset_val = pwdata_i[PSV_EXT_PRE_LSB];
        end
        // writing ones clears pending flags directly
        psv_byte_addr(PSV_IDX_PENDING): clr_vec = pwdata_i[8:0];
        psv_byte_addr(PSV_IDX_SRC_EN):  s_nxt.mask = pwdata_i[8:0];
        psv_byte_addr(PSV_IDX_VEC_EN): begin
          s_nxt.ven  = pwdata_i[3:0];
          s_nxt.mask = s_r.mask | psv_onehot(pwdata_i[3:0]);
        end
        psv_byte_addr(PSV_IDX_VEC_DIS): begin
          s_nxt.vdis = pwdata_i[3:0];
          s_nxt.mask = s_r.mask & ~psv_onehot(pwdata_i[3:0]);
        end
        psv_byte_addr(PSV_IDX_CEILING): s_nxt.ceil = pwdata_i[3:0];
        psv_byte_addr(PSV_IDX_CUR_VEC): clr_vec = psv_onehot(pwdata_i[3:0]);
        default: ;
      endcase
    end

    // a capture overrides a same-cycle software write
    if (capture_evt) begin
      s_nxt.match_b = phase_acc_i;
    end

    // new events win over a clear in the same cycle
    s_nxt.pend = (s_r.pend & ~clr_vec) | set_vec;

    // follows the flags that will be stored this edge
    s_nxt.irq = (|(s_nxt.pend & s_nxt.mask))
                && (psv_first(s_nxt.pend & s_nxt.mask) < s_nxt.ceil);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r      <= '0;
      s_r.ceil <= PSV_RST_CEILING;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign prdata_o      = {16'h0000, s_r.rdata};
  assign pready_o      = s_r.pready;
  assign pslverr_o     = s_r.pslverr;
  assign irq_o         = s_r.irq;
  assign sync_reload_o = s_r.sync_reload;

  a_reload_needs_match: assert property (@(posedge clk_i) disable iff (rst_i)
    sync_reload_o |-> (s_r.pend[0] && $past(s_r.use_a) == PSV_USE_A_RELOAD))
    else $error("sync reload without first match");

  a_match_a_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && phase_inc_i && s_r.use_a != PSV_USE_OFF && phase_acc_i == s_r.match_a)
    |=> s_r.pend[0])
    else $error("first match flag not set");

  a_match_a_unused: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && s_r.use_a == PSV_USE_OFF) |=> !sync_reload_o)
    else $error("reload while first comparator unused");

  a_capture_copy: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && sif.capture && s_r.use_b == PSV_USE_B_CAPTURE)
    |=> (s_r.match_b == $past(phase_acc_i) && s_r.pend[1]))
    else $error("capture did not copy accumulator");

  a_vector_clear_one: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr && !s_r.pslverr && paddr_i == psv_byte_addr(PSV_IDX_CUR_VEC)
     && pwdata_i[3:0] == 4'h4 && !reload_evt_i[2])
    |=> (!s_r.pend[4] && s_r.pend[8:5] == ($past(s_r.pend[8:5]) | $past(set_vec[8:5]))
         && s_r.pend[3:0] == ($past(s_r.pend[3:0]) | $past(set_vec[3:0]))))
    else $error("vector write cleared wrong flags");

  a_venable_one_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr && !s_r.pslverr && paddr_i == psv_byte_addr(PSV_IDX_VEC_EN)
     && pwdata_i[3:0] == 4'h4)
    |=> (s_r.mask == ($past(s_r.mask) | 9'h010)))
    else $error("vector enable changed other sources");

  a_vdisable_one_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr && !s_r.pslverr && paddr_i == psv_byte_addr(PSV_IDX_VEC_DIS)
     && pwdata_i[3:0] == 4'h2)
    |=> (s_r.mask == ($past(s_r.mask) & 9'h1FB)))
    else $error("vector disable changed other sources");

  a_irq_ceiling: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o == ((|(s_r.pend & s_r.mask)) && (cur_vec < s_r.ceil)))
    else $error("irq disagrees with ceiling");

  a_apb_answer_one: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && psel_i && !penable_i) |=> pready_o ##1 (!pready_o || !$past(ce_i)))
    else $error("apb answer timing wrong");

  a_match_b_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && phase_inc_i && s_r.use_b == PSV_USE_B_MATCH && phase_acc_i == s_r.match_b)
    |=> s_r.pend[1])
    else $error("second match flag not set");

  a_second_unused: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && s_r.use_b == PSV_USE_OFF && !s_r.pend[1]) |=> !s_r.pend[1])
    else $error("second flag set while comparator unused");

  // only a capture or a software write may move the second register
  a_match_b_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && s_r.use_b != PSV_USE_B_CAPTURE && !wr) |=> $stable(s_r.match_b))
    else $error("second register changed without capture");

  a_match_a_only: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && s_r.use_a == PSV_USE_A_MATCH) |=> !sync_reload_o)
    else $error("reload in match only mode");

  a_upper_bits_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (pready_o && psel_i && !pwrite_i && (paddr_i == psv_byte_addr(PSV_IDX_MATCH_A)
     || paddr_i == psv_byte_addr(PSV_IDX_MATCH_B))) |-> prdata_o[31:12] == 20'h00000)
    else $error("compare register upper bits not zero");

  a_vector_none: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && setup && !pwrite_i && paddr_i == psv_byte_addr(PSV_IDX_CUR_VEC))
    |=> ((prdata_o[3:0] == PSV_VEC_NONE) == ($past(s_r.pend & s_r.mask) == 9'h000)))
    else $error("unused vector reported wrongly");

  // returned vector is enabled pending and nothing below it is
  a_vector_lowest: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && setup && !pwrite_i && paddr_i == psv_byte_addr(PSV_IDX_CUR_VEC))
    |=> (prdata_o[3:0] == PSV_VEC_NONE)
        || (((($past(s_r.pend & s_r.mask) >> prdata_o[3:0]) & 9'h001) == 9'h001)
            && (($past(s_r.pend & s_r.mask) & ((9'h001 << prdata_o[3:0]) - 9'h001)) == 9'h000)))
    else $error("current vector not the lowest pending");

  a_reset_values: assert property (@(posedge clk_i)
    $fell(rst_i) |-> (s_r.ceil == PSV_RST_CEILING && s_r.mask == 9'h000 && !irq_o))
    else $error("wrong state after reset");

  a_preset_decode: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr && !s_r.pslverr && paddr_i == psv_byte_addr(PSV_IDX_EXT_CFG))
    |=> (s_r.preset_go == $past(pwdata_i[PSV_EXT_PRE_LSB + 1]))
        && (!s_r.preset_go || s_r.preset_val == $past(pwdata_i[PSV_EXT_PRE_LSB])))
    else $error("filter preset decoded wrongly");

  a_pend_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !wr) |=> ((s_r.pend & $past(s_r.pend)) == $past(s_r.pend)))
    else $error("pending flag dropped without a write");

  a_mask_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr && !s_r.pslverr && paddr_i == psv_byte_addr(PSV_IDX_SRC_EN))
    |=> (s_r.mask == $past(pwdata_i[8:0])))
    else $error("mask write not stored");

  a_ceiling_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wr && !s_r.pslverr && paddr_i == psv_byte_addr(PSV_IDX_CEILING))
    |=> (s_r.ceil == $past(pwdata_i[3:0])))
    else $error("ceiling write not stored");

  a_dma_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && dma_idle_i != 3'h0)
    |=> ((s_r.pend[8:6] & $past(dma_idle_i)) == $past(dma_idle_i)))
    else $error("dma idle flag not set");

endmodule // psv_top
`default_nettype wire

// ===== psv_src_model.sv
// Purpose: far-side model driving phase, sync and channel events
// Assumes: tasks are entered right after a rising edge
// Notes:   accumulator shows inverted junk while not qualified
`timescale 1ns/1ps
`default_nettype none
module psv_src_model (
  // clock
  input  wire logic   clk_i,
  // events toward the block
  output logic [11:0] phase_acc_o,
  output logic        phase_inc_o,
  output logic [3:0]  ext_sync_o,
  output logic [2:0]  reload_evt_o,
  output logic        reload_err_o,
  output logic [2:0]  dma_idle_o
);
  logic [11:0] acc_r;
  logic        hold_r;

  initial begin
    acc_r = 12'h000;
    hold_r = 1'b0;
    phase_inc_o = 1'b0;
    ext_sync_o = 4'h0;
    reload_evt_o = 3'h0;
    reload_err_o = 1'b0;
    dma_idle_o = 3'h0;
  end

  // value is only trusted with an increment or a held capture window
  assign phase_acc_o = (phase_inc_o || hold_r) ? acc_r : ~acc_r;

  task automatic inc(input logic [11:0] a);
    acc_r <= a;
    phase_inc_o <= 1'b1;
    @(posedge clk_i);
    phase_inc_o <= 1'b0;
  endtask

  task automatic hold(input logic [11:0] a);
    acc_r <= a;
    hold_r <= 1'b1;
  endtask

  task automatic set_sync(input logic [3:0] v);
    ext_sync_o <= v;
  endtask

  task automatic evt(input logic [2:0] rl, input logic er, input logic [2:0] dm);
    reload_evt_o <= rl;
    reload_err_o <= er;
    dma_idle_o <= dm;
    @(posedge clk_i);
    reload_evt_o <= 3'h0;
    reload_err_o <= 1'b0;
    dma_idle_o <= 3'h0;
  endtask
endmodule // psv_src_model
`default_nettype wire

// ===== test_phase_sync_and_vector_irq.sv
// Purpose: self-checking bench for the phase sync and vector irq block
// Assumes: apb slave answers in the access cycle right after setup
// Notes:   event sources come from psv_src_model
`timescale 1ns/1ps
`default_nettype none
module test_phase_sync_and_vector_irq;
  import psv_pkg::*;
  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  logic        ce      = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  psv_addr_t   paddr   = '0;
  logic [31:0] pwdata  = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [11:0] acc;
  logic        inc;
  logic [3:0]  sync;
  logic [2:0]  rl;
  logic        rerr;
  logic [2:0]  dma;
  logic        irq;
  logic        sreload;
  logic [31:0] r;
  logic        e;
  int          failures = 0;
  int          checks   = 0;
  int          cyc      = 0;
  logic [7:0]  regs [8] = '{PSV_IDX_MATCH_A, PSV_IDX_MATCH_B, PSV_IDX_USAGE,
    PSV_IDX_EXT_CFG, PSV_IDX_PENDING, PSV_IDX_SRC_EN, PSV_IDX_VEC_EN, PSV_IDX_VEC_DIS};

  always #50 clk_i = ~clk_i;

  psv_src_model src (.clk_i(clk_i), .phase_acc_o(acc), .phase_inc_o(inc),
    .ext_sync_o(sync), .reload_evt_o(rl), .reload_err_o(rerr), .dma_idle_o(dma));

  psv_top DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .phase_acc_i(acc),
    .phase_inc_i(inc), .ext_sync_i(sync), .reload_evt_i(rl), .reload_err_i(rerr),
    .dma_idle_i(dma), .irq_o(irq), .sync_reload_o(sreload));

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string s);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp, input string s);
    chk_word({31'h0, got}, {31'h0, exp}, s);
  endtask

  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end

  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    chk_word(32'(n), 32'h0000_0001, "answer latency");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    apb(1'b1, idx, {16'h0000, d});
    chk_flag(e, 1'b0, "write error");
  endtask

  task automatic rd(input logic [7:0] idx, input logic [15:0] x);
    apb(1'b0, idx, 32'h0000_0000);
    chk_word(r, {16'h0000, x}, $sformatf("read %h", idx));
    chk_flag(e, 1'b0, "read error");
  endtask

  task automatic irq_is(input logic x);
    repeat (2) @(posedge clk_i);
    chk_flag(irq, x, "irq");
  endtask

  task automatic cap_step(input logic [15:0] cfg, input logic [3:0] lv, input logic [11:0] a);
    src.hold(a);
    wr(PSV_IDX_EXT_CFG, cfg);
    src.set_sync(lv);
    repeat (16) @(posedge clk_i);
    rd(PSV_IDX_PENDING, 16'h0002);
    rd(PSV_IDX_MATCH_B, {4'h0, a});
    wr(PSV_IDX_PENDING, 16'h0002);
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (regs[i]) rd(regs[i], 16'h0000);
    rd(PSV_IDX_CEILING, 16'h0009);
    rd(PSV_IDX_CUR_VEC, 16'h0009);
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk_word(r, 32'h0000_0000, "unmapped data");
    chk_flag(e, 1'b1, "unmapped error");
    wr(PSV_IDX_MATCH_A, 16'hFFFF);
    rd(PSV_IDX_MATCH_A, 16'h0FFF);
    wr(PSV_IDX_MATCH_B, 16'hF5A5);
    rd(PSV_IDX_MATCH_B, 16'h05A5);
    $display("test registers done");
    wr(PSV_IDX_MATCH_A, 16'h0123);
    for (int u = 0; u < 3; u++) begin
      wr(PSV_IDX_USAGE, 16'(u));
      src.inc(12'h123);
      @(posedge clk_i);
      chk_flag(sreload, u == 1, "reload pulse");
      @(posedge clk_i);
      chk_flag(sreload, 1'b0, "reload length");
      rd(PSV_IDX_PENDING, {15'h0000, u != 0});
      wr(PSV_IDX_PENDING, 16'h0001);
    end
    wr(PSV_IDX_MATCH_B, 16'h0077);
    wr(PSV_IDX_USAGE, 16'h0008);
    src.inc(12'h077);
    rd(PSV_IDX_PENDING, 16'h0002);
    wr(PSV_IDX_PENDING, 16'h0002);
    $display("test compare done");
    src.evt(3'b101, 1'b1, 3'b001);
    rd(PSV_IDX_PENDING, 16'h0074);
    rd(PSV_IDX_CUR_VEC, 16'h0009);
    irq_is(1'b0);
    wr(PSV_IDX_VEC_EN, 16'h0004);
    rd(PSV_IDX_SRC_EN, 16'h0010);
    rd(PSV_IDX_CUR_VEC, 16'h0004);
    irq_is(1'b1);
    wr(PSV_IDX_VEC_EN, 16'h0002);
    wr(PSV_IDX_VEC_EN, 16'h0008);
    rd(PSV_IDX_SRC_EN, 16'h0114);
    rd(PSV_IDX_CUR_VEC, 16'h0002);
    wr(PSV_IDX_VEC_DIS, 16'h0002);
    rd(PSV_IDX_SRC_EN, 16'h0110);
    wr(PSV_IDX_CEILING, 16'h0004);
    irq_is(1'b0);
    wr(PSV_IDX_CEILING, 16'h0005);
    irq_is(1'b1);
    wr(PSV_IDX_CUR_VEC, 16'h0004);
    rd(PSV_IDX_PENDING, 16'h0064);
    rd(PSV_IDX_CUR_VEC, 16'h0009);
    irq_is(1'b0);
    wr(PSV_IDX_SRC_EN, 16'h01FF);
    rd(PSV_IDX_CUR_VEC, 16'h0002);
    wr(PSV_IDX_PENDING, 16'h01FF);
    wr(PSV_IDX_SRC_EN, 16'h0000);
    rd(PSV_IDX_PENDING, 16'h0000);
    ce <= 1'b0;
    src.evt(3'b010, 1'b0, 3'b000);
    ce <= 1'b1;
    rd(PSV_IDX_PENDING, 16'h0000);
    $display("test vectors done");
    wr(PSV_IDX_USAGE, 16'h0004);
    wr(PSV_IDX_EXT_CFG, 16'h0822);
    src.set_sync(4'b1011);
    repeat (16) @(posedge clk_i);
    src.set_sync(4'b1111);
    repeat (3) @(posedge clk_i);
    src.set_sync(4'b1011);
    repeat (16) @(posedge clk_i);
    rd(PSV_IDX_PENDING, 16'h0000);
    for (int s = 0; s < 4; s++) begin
      cap_step(16'h0820 | 16'(s), 4'(1 << s), 12'h400 + 12'(s));
    end
    cap_step(16'h1023, 4'b0000, 12'hABC);
    cap_step(16'h1C23, 4'b0000, 12'h135);
    rd(PSV_IDX_EXT_CFG, 16'h1C23);
    src.set_sync(4'b1000);
    repeat (16) @(posedge clk_i);
    rd(PSV_IDX_PENDING, 16'h0000);
    $display("test capture done");
    close_out();
  end
endmodule // test_phase_sync_and_vector_irq
`default_nettype wire
